// file: tmio_regs.svh
// register offsets, field positions, reset values and prescaler masks of the timer block
`ifndef TMIO_REGS_SVH
`define TMIO_REGS_SVH
`define TMIO_START_OFS    6'h00
`define TMIO_CH_BASE      6'h10
`define TMIO_MODE_OFS     4'h0
`define TMIO_IOAB_OFS     4'h1
`define TMIO_IOCD_OFS     4'h2
`define TMIO_STAT_OFS     4'h3
`define TMIO_CNT_OFS      4'h4
`define TMIO_GRA_OFS      4'h5
`define TMIO_GRD_OFS      4'h8
`define TMIO_CKS_OFS      4'h9
`define TMIO_MODE_BFB_BIT 5
`define TMIO_MODE_BFA_BIT 4
`define TMIO_MODE_FIXED   2'h3
`define TMIO_MODE_RST     6'h00
`define TMIO_IO_RST       8'h00
`define TMIO_START_RST    3'h0
`define TMIO_CKS_RST      3'h0
`define TMIO_CKS_DIV1     3'h0
`define TMIO_CKS_DIV4     3'h1
`define TMIO_CKS_DIV16    3'h2
`define TMIO_CKS_DIV64    3'h3
`define TMIO_CKS_EXTA     3'h4
`define TMIO_CKS_EXTB     3'h5
`define TMIO_CKS_EXTC     3'h6
`define TMIO_CKS_DIV1024  3'h7
`define TMIO_DIV4_M       10'h003
`define TMIO_DIV16_M      10'h00f
`define TMIO_DIV64_M      10'h03f
`define TMIO_DIV1024_M    10'h3ff
`endif

// file: tmio_pkg.sv
// types shared by the timer mode and io control block
package tmio_pkg;
  typedef enum logic [3:0] {
    TMIO_NORMAL, TMIO_RESV, TMIO_PWM1, TMIO_PWM2,
    TMIO_PH1, TMIO_PH2, TMIO_PH3, TMIO_PH4, TMIO_UNDEF
  } tmio_mode_e;

  typedef struct packed {
    logic o;
    logic oe;
  } tmio_pin_s;

  typedef struct packed {
    logic [3:0] field;
    logic       active;
    logic       run;
    logic       clr;
  } tmio_ctl_s;

  // enum order follows the low three mode bits
  function automatic tmio_mode_e tmio_decode(input logic [3:0] md);
    return md[3] ? TMIO_UNDEF : tmio_mode_e'({1'b0, md[2:0]});
  endfunction
endpackage

// file: tmio_clk_sel.sv
// count clock selection and phase counting decode for one channel
`timescale 1ns/10ps
`include "tmio_regs.svh"
module tmio_clk_sel
  import tmio_pkg::*;
  #(parameter int PW = 10)
  (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic [2:0]    sel_i,
  input  wire logic [PW-1:0] pre_i,
  input  wire logic [2:0]    ext_i,
  input  wire logic          phase_i,
  input  wire logic          pha_i,
  input  wire logic          phb_i,
  output logic               tick_o,
  output logic               up_o
  );
  if (PW != 10) begin : g_chk
    $error("prescaler width must be 10");
  end

  logic [2:0] ext_q, ext_nxt;
  logic [1:0] ph_q, ph_nxt;
  logic       t, ea, eb;
  logic [2:0] rise;

  always_comb begin
    ext_nxt = ext_i;
    ph_nxt  = {phb_i, pha_i};
    rise    = ext_i & ~ext_q;
    ea      = pha_i ^ ph_q[0];
    eb      = phb_i ^ ph_q[1];
    unique case (sel_i)
      `TMIO_CKS_DIV1:    t = 1'b1;
      `TMIO_CKS_DIV4:    t = (pre_i & `TMIO_DIV4_M) == `TMIO_DIV4_M;
      `TMIO_CKS_DIV16:   t = (pre_i & `TMIO_DIV16_M) == `TMIO_DIV16_M;
      `TMIO_CKS_DIV64:   t = (pre_i & `TMIO_DIV64_M) == `TMIO_DIV64_M;
      `TMIO_CKS_EXTA:    t = rise[0];
      `TMIO_CKS_EXTB:    t = rise[1];
      `TMIO_CKS_EXTC:    t = rise[2];
      `TMIO_CKS_DIV1024: t = (pre_i & `TMIO_DIV1024_M) == `TMIO_DIV1024_M;
    endcase
    tick_o = phase_i ? (ea | eb) : t;
    up_o   = phase_i ? ((ea & (pha_i ^ phb_i)) | (eb & ~(pha_i ^ phb_i))) : 1'b1;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ext_q <= 3'h0;
      ph_q  <= 2'h0;
    end else if (ce_i) begin
      ext_q <= ext_nxt;
      ph_q  <= ph_nxt;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  div16_tap_a: assert property (!phase_i && sel_i == `TMIO_CKS_DIV16 |-> tick_o == (pre_i[3:0] == 4'hf))
    else $error("div16 tick wrong");
  div1_tap_a: assert property (!phase_i && sel_i == `TMIO_CKS_DIV1 |-> tick_o)
    else $error("div1 tick missing");
  phase_edge_a: assert property (phase_i && tick_o && $past(ce_i) |-> !$stable(pha_i) || !$stable(phb_i))
    else $error("phase tick without phase edge");
endmodule

// file: tmio_gr_unit.sv
// compare and capture logic with pin control for one general register
`timescale 1ns/10ps
module tmio_gr_unit
  import tmio_pkg::*;
  #(parameter int W = 16)
  (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire tmio_ctl_s    ctl_i,
  input  wire logic [W-1:0] cnt_i,
  input  wire logic [W-1:0] gr_i,
  input  wire logic         upd_i,
  input  wire logic         pin_i,
  output logic              ev_o,
  output logic              cap_o,
  output tmio_pin_s         pin_o
  );
  if (W < 2) begin : g_chk
    $error("counter too narrow");
  end

  logic pin_q, pin_nxt, lvl_r, lvl_nxt, oc, ic, edg, match;
  logic [3:0] f;

  always_comb begin
    f       = ctl_i.field;
    pin_nxt = pin_i;
    oc      = ctl_i.active && !f[3];
    ic      = ctl_i.active && f[3:2] == 2'h2;
    edg     = f[1] ? (pin_i ^ pin_q) : (f[0] ? (pin_q & ~pin_i) : (pin_i & ~pin_q));
    match   = oc && ctl_i.run && upd_i && cnt_i == gr_i;
    cap_o   = ic && edg;
    ev_o    = match || cap_o;
    lvl_nxt = lvl_r;
    if (!ctl_i.run) begin
      lvl_nxt = f[2];
    end else if (ctl_i.clr) begin
      lvl_nxt = f[2];
    end else if (match) begin
      unique case (f[1:0])
        2'h1:    lvl_nxt = 1'b0;
        2'h2:    lvl_nxt = 1'b1;
        2'h3:    lvl_nxt = ~lvl_r;
        2'h0:    lvl_nxt = lvl_r;
      endcase
    end
    pin_o.o  = lvl_r;
    pin_o.oe = oc && f[1:0] != 2'h0;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
      lvl_r <= 1'b0;
    end else if (ce_i) begin
      pin_q <= pin_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  init_level_a: assert property (ce_i && !ctl_i.run && !f[3] && ctl_i.active |=> lvl_r == $past(f[2]))
    else $error("initial level not driven while stopped");
  match_high_a: assert property (ce_i && match && !ctl_i.clr && f[1:0] == 2'h2 |=> lvl_r)
    else $error("compare did not drive one");
  no_prohibit_a: assert property (f[3:2] == 2'h3 |-> !cap_o && !ev_o)
    else $error("prohibited field produced event");
  pwm2_clear_a: assert property (ce_i && ctl_i.run && ctl_i.clr |=> lvl_r == $past(f[2]))
    else $error("pwm2 clear level wrong");
endmodule

// file: tmio_top.sv
// three channel timer: mode, clock select, io control and compare/capture registers
// What this block does
// - Ch2 codes 1-7 pick prescale or pins.
// - Ch2 code 000 counts undivided clock.
// - Phase counting ignores clock source selection.
// - Mode bits 7,6 read one, ignore writes.
// - Ch0 bit5 pairs B with D buffer.
// - Ch0 bit4 pairs A with C buffer.
// - Ch1/2 buffer bits read zero, fixed.
// - Low mode field selects normal, pwm, phase.
// - Initial pin level while stopped and at pwm2 clear.
// - Pwm mode 2 sets level at clear.
// - Buffer registers ignore io control field.
// - Ab io control: high nibble B, low A.
// - Ch0 cd io control: high D, low C.
// - Top bit 0: compare, low bits action.
// - Second bit gives initial output level.
// - Pattern 10: capture edge; 11xx prohibited.
// - Compare equality sets status flag.
// - Capture edge copies counter, sets flag.
`timescale 1ns/10ps
`include "tmio_regs.svh"
module tmio_top
  import tmio_pkg::*;
  #(parameter int CW = 16,
    parameter int PW = 10)
  (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        ext_clock_pin_a_i,
  input  wire logic        ext_clock_pin_b_i,
  input  wire logic        ext_clock_pin_c_i,
  input  wire logic        phase_pin_d_i,
  input  wire logic [7:0]  pin_i,
  output logic      [7:0]  pin_o,
  output logic      [7:0]  pin_oe_o
  );
  if (CW != 16 || PW != 10) begin : g_chk
    $error("counter must be 16 bits and prescaler 10 bits");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // general register index: 0..3 ch0 a..d, 4/5 ch1 a/b, 6/7 ch2 a/b
  function automatic int gch(input int g);
    return (g < 4) ? 0 : ((g < 6) ? 1 : 2);
  endfunction

  function automatic int glt(input int g);
    return (g < 4) ? g : g % 2;
  endfunction

  logic [2:0]    start_r, start_nxt;
  logic [5:0]    mode_r [3];
  logic [5:0]    mode_nxt [3];
  logic [2:0]    cks_r [3];
  logic [2:0]    cks_nxt [3];
  logic [7:0]    ioab_r [3];
  logic [7:0]    ioab_nxt [3];
  logic [7:0]    iocd_r, iocd_nxt;
  logic [PW-1:0] pre_r, pre_nxt;
  logic [15:0]   rdata_r, rdata_nxt;
  logic [3:0]    flag_r [3];
  logic [3:0]    flag_nxt [3];
  logic [CW-1:0] cnt_r [3];
  logic [CW-1:0] cnt_nxt [3];
  logic [CW-1:0] gr_r [8];
  logic [CW-1:0] gr_nxt [8];
  logic [2:0]    upd_r, upd_nxt;
  logic [5:0]    choff;
  logic [1:0]    ch;
  logic [3:0]    ofs, gi;
  logic          chv, grv;
  logic [2:0]    tick, up, phm, pwm2, clr_w;
  logic [7:0]    ev, cap;
  logic [3:0]    fld [8];
  tmio_mode_e    md_e [3];
  tmio_ctl_s     ctl [8];
  tmio_pin_s     pin_s [8];

  assign choff   = addr_i - `TMIO_CH_BASE;
  assign ch      = choff[5:4];
  assign ofs     = choff[3:0];
  assign chv     = addr_i >= `TMIO_CH_BASE && ch != 2'h3;
  assign gi      = (ch == 2'h0) ? ofs - `TMIO_GRA_OFS : {1'b0, ch, 1'b0} + 4'h2 + ofs - `TMIO_GRA_OFS;
  assign grv     = ofs >= `TMIO_GRA_OFS && ofs <= `TMIO_GRD_OFS && (ch == 2'h0 || ofs < 4'h7);
  assign rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // per channel mode decode and count clock
  for (genvar c = 0; c < 3; c++) begin : g_ch
    localparam int GA = (c == 0) ? 0 : 2 + 2 * c;
    assign md_e[c]  = tmio_decode(mode_r[c][3:0]);
    // phase counting only ch1 and ch2
    assign phm[c]   = (c != 0) && md_e[c] inside {TMIO_PH1, TMIO_PH2, TMIO_PH3, TMIO_PH4};
    assign pwm2[c]  = md_e[c] == TMIO_PWM2;
    assign clr_w[c] = start_r[c] && (md_e[c] == TMIO_PWM1 || pwm2[c]) && ev[GA] && !cap[GA];
    tmio_clk_sel #(.PW(PW)) u_cks (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .sel_i   (cks_r[c]),
      .pre_i   (pre_r),
      .ext_i   ({ext_clock_pin_c_i, ext_clock_pin_b_i, ext_clock_pin_a_i}),
      .phase_i (phm[c]),
      .pha_i   ((c == 2) ? ext_clock_pin_c_i : ext_clock_pin_a_i),
      .phb_i   ((c == 2) ? phase_pin_d_i : ext_clock_pin_b_i),
      .tick_o  (tick[c]),
      .up_o    (up[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per general register compare and capture
  for (genvar g = 0; g < 8; g++) begin : g_gr
    localparam int CH = gch(g);
    localparam int LT = glt(g);
    assign fld[g] = (LT == 0) ? ioab_r[CH][3:0] : (LT == 1) ? ioab_r[CH][7:4] :
                    (LT == 2) ? iocd_r[3:0] : iocd_r[7:4];
    // d silent while paired with b
    // c silent while paired with a
    assign ctl[g] = '{field:  fld[g],
                      active: !((LT == 2 && mode_r[0][`TMIO_MODE_BFA_BIT]) ||
                                (LT == 3 && mode_r[0][`TMIO_MODE_BFB_BIT])),
                      run:    start_r[CH],
                      clr:    clr_w[CH] && pwm2[CH]};
    tmio_gr_unit #(.W(CW)) u_gr (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .ctl_i   (ctl[g]),
      .cnt_i   (cnt_r[CH]),
      .gr_i    (gr_r[g]),
      .upd_i   (upd_r[CH]),
      .pin_i   (pin_i[g]),
      .ev_o    (ev[g]),
      .cap_o   (cap[g]),
      .pin_o   (pin_s[g])
    );
    assign pin_o[g]    = pin_s[g].o;
    assign pin_oe_o[g] = pin_s[g].oe;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers and read path
  always_comb begin
    start_nxt = start_r;
    iocd_nxt  = iocd_r;
    pre_nxt   = pre_r + 1'b1;
    rdata_nxt = 16'h0000;
    if (wr_i && addr_i == `TMIO_START_OFS) begin
      start_nxt = wdata_i[2:0];
    end
    if (wr_i && chv && ch == 2'h0 && ofs == `TMIO_IOCD_OFS) begin
      iocd_nxt = wdata_i[7:0];
    end
    for (int c = 0; c < 3; c++) begin
      mode_nxt[c] = mode_r[c];
      cks_nxt[c]  = cks_r[c];
      ioab_nxt[c] = ioab_r[c];
      if (wr_i && chv && ch == 2'(c)) begin
        if (ofs == `TMIO_MODE_OFS) begin
          mode_nxt[c] = (c == 0) ? wdata_i[5:0] : {2'h0, wdata_i[3:0]};
        end
        if (ofs == `TMIO_CKS_OFS) begin
          cks_nxt[c] = wdata_i[2:0];
        end
        if (ofs == `TMIO_IOAB_OFS) begin
          ioab_nxt[c] = wdata_i[7:0];
        end
      end
    end
    if (rd_i && addr_i == `TMIO_START_OFS) begin
      rdata_nxt = {13'h0000, start_r};
    end else if (rd_i && chv) begin
      case (ofs)
        `TMIO_MODE_OFS: rdata_nxt = {8'h00, `TMIO_MODE_FIXED, mode_r[ch]};
        `TMIO_IOAB_OFS: rdata_nxt = {8'h00, ioab_r[ch]};
        `TMIO_IOCD_OFS: rdata_nxt = (ch == 2'h0) ? {8'h00, iocd_r} : 16'h0000;
        `TMIO_STAT_OFS: rdata_nxt = {12'h000, flag_r[ch]};
        `TMIO_CNT_OFS:  rdata_nxt = cnt_r[ch];
        `TMIO_CKS_OFS:  rdata_nxt = {13'h0000, cks_r[ch]};
        default:        rdata_nxt = grv ? gr_r[gi[2:0]] : 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      start_r <= `TMIO_START_RST;
      iocd_r  <= `TMIO_IO_RST;
      pre_r   <= '0;
      rdata_r <= 16'h0000;
      for (int c = 0; c < 3; c++) begin
        mode_r[c] <= `TMIO_MODE_RST;
        cks_r[c]  <= `TMIO_CKS_RST;
        ioab_r[c] <= `TMIO_IO_RST;
      end
    end else if (ce_i) begin
      start_r <= start_nxt;
      iocd_r  <= iocd_nxt;
      pre_r   <= pre_nxt;
      rdata_r <= rdata_nxt;
      for (int c = 0; c < 3; c++) begin
        mode_r[c] <= mode_nxt[c];
        cks_r[c]  <= cks_nxt[c];
        ioab_r[c] <= ioab_nxt[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counters, general registers and status flags
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      cnt_nxt[c] = cnt_r[c];
      upd_nxt[c] = 1'b0;
      if (start_r[c] && tick[c]) begin
        cnt_nxt[c] = up[c] ? cnt_r[c] + 1'b1 : cnt_r[c] - 1'b1;
        upd_nxt[c] = 1'b1;
      end
      if (clr_w[c]) begin
        cnt_nxt[c] = '0;
      end
      if (wr_i && chv && ch == 2'(c) && ofs == `TMIO_CNT_OFS) begin
        cnt_nxt[c] = wdata_i[CW-1:0];
      end
      // a flag raised in the clearing cycle survives
      flag_nxt[c] = flag_r[c];
      if (wr_i && chv && ch == 2'(c) && ofs == `TMIO_STAT_OFS) begin
        flag_nxt[c] = flag_r[c] & wdata_i[3:0];
      end
    end
    flag_nxt[0] = flag_nxt[0] | ev[3:0];
    flag_nxt[1] = flag_nxt[1] | {2'h0, ev[5:4]};
    flag_nxt[2] = flag_nxt[2] | {2'h0, ev[7:6]};
    for (int g = 0; g < 8; g++) begin
      gr_nxt[g] = gr_r[g];
      if (wr_i && grv && gi == 4'(g)) begin
        gr_nxt[g] = wdata_i[CW-1:0];
      end
      if (cap[g]) begin
        gr_nxt[g] = cnt_r[gch(g)];
      end
    end
    // paired buffers: compare reloads from buffer, capture pushes old value out
    for (int p = 0; p < 2; p++) begin
      if (mode_r[0][`TMIO_MODE_BFA_BIT + p]) begin
        if (ev[p] && !cap[p]) begin
          gr_nxt[p] = gr_r[p + 2];
        end
        if (cap[p]) begin
          gr_nxt[p + 2] = gr_r[p];
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      upd_r <= 3'h0;
      for (int c = 0; c < 3; c++) begin
        cnt_r[c]  <= '0;
        flag_r[c] <= 4'h0;
      end
      for (int g = 0; g < 8; g++) begin
        gr_r[g] <= '0;
      end
    end else if (ce_i) begin
      upd_r <= upd_nxt;
      for (int c = 0; c < 3; c++) begin
        cnt_r[c]  <= cnt_nxt[c];
        flag_r[c] <= flag_nxt[c];
      end
      for (int g = 0; g < 8; g++) begin
        gr_r[g] <= gr_nxt[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_mode_rd;
    ce_i && rd_i && chv && ofs == `TMIO_MODE_OFS;
  endsequence
  sequence s_cap_a1;
    ce_i && cap[4];
  endsequence
  mode_fixed_a: assert property (s_mode_rd |=> rdata_o[7:6] == 2'h3)
    else $error("mode upper bits not one");
  buf_bits_zero_a: assert property (s_mode_rd ##0 ch != 2'h0 |=> rdata_o[5:4] == 2'h0)
    else $error("ch1/ch2 buffer bits not zero");
  buf_c_silent_a: assert property (mode_r[0][`TMIO_MODE_BFA_BIT] |-> !ev[2])
    else $error("paired c produced event");
  buf_d_silent_a: assert property (mode_r[0][`TMIO_MODE_BFB_BIT] |-> !ev[3])
    else $error("paired d produced event");
  io_write_a: assert property (ce_i && wr_i && chv && ch == 2'h1 && ofs == `TMIO_IOAB_OFS |=>
                               ioab_r[1] == $past(wdata_i[7:0]))
    else $error("io control write not taken next edge");
  match_flag_a: assert property (ce_i && ev[4] |=> flag_r[1][0])
    else $error("flag not set by event");
  capture_copy_a: assert property (s_cap_a1 |=> gr_r[4] == $past(cnt_r[1]) && flag_r[1][0])
    else $error("capture did not copy counter");
  stop_hold_a: assert property (ce_i && !start_r[1] && !clr_w[1] && !(wr_i && chv && ch == 2'h1) |=>
                                $stable(cnt_r[1]))
    else $error("stopped counter moved");
endmodule

// file: tmio_pin_model.sv
// far side model: capture/compare pin wires and external clock sources
`timescale 1ns/10ps
module tmio_pin_model
  (
  input  wire logic       clock_i,
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  output logic      [7:0] pin_i,
  output logic      [3:0] ext_o
  );
  logic [7:0] lvl_r;

  initial begin
    lvl_r = 8'h00;
    ext_o = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wire level: the timer wins where it drives, the source drives elsewhere
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & lvl_r);

  ////////////////////////////////////////////////////////////////////////////
  // pulses last two cycles high, three low, so a synchronous edge detect sees each
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clock_i);
      ext_o[k] <= 1'b1;
      repeat (2) @(posedge clock_i);
      ext_o[k] <= 1'b0;
      repeat (2) @(posedge clock_i);
    end
  endtask

  task automatic set_pin(input int k, input logic v);
    @(posedge clock_i);
    lvl_r[k] <= v;
  endtask
endmodule

// file: tmio_top_tb.sv
// self-checking bench for the timer mode and io control block
`timescale 1ns/10ps
module tmio_top_tb;
  logic        clock_i;
  logic        rst_i;
  logic        ce_i;
  logic        wr_i;
  logic        rd_i;
  logic [5:0]  addr_i;
  logic [15:0] wdata_i;
  logic [15:0] rdata_o;
  logic [7:0]  pin_i;
  logic [7:0]  pin_o;
  logic [7:0]  pin_oe_o;
  logic [3:0]  ext;
  logic [15:0] exp_q[$];
  logic        rd_seen;
  logic [31:0] r;
  logic [15:0] v;
  int          n_mismatch;
  int          checks;

  tmio_top DUT (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_clock_pin_a_i(ext[0]), .ext_clock_pin_b_i(ext[1]),
    .ext_clock_pin_c_i(ext[2]), .phase_pin_d_i(ext[3]), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  tmio_pin_model P (.clock_i(clock_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_i(pin_i), .ext_o(ext));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one idle cycle between strobes keeps each strobe assigned once per step
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(e);
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask

  // enable mask m against eo, level mask lm against ev
  task automatic pc(input logic [7:0] m, input logic [7:0] eo, input logic [7:0] lm, input logic [7:0] ev);
    @(negedge clock_i);
    chk("pin_oe_o", {8'h00, eo}, {8'h00, pin_oe_o & m});
    chk("pin_o", {8'h00, ev}, {8'h00, pin_o & lm});
  endtask

  // channel 2 counts three pulses of source k under clock code
  task automatic ext_run(input logic [2:0] code, input int k, input logic [15:0] e);
    wr(6'h39, {13'h0000, code});
    wr(6'h34, 16'h0000);
    wr(6'h00, 16'h0004);
    P.pulse(k, 3);
    repeat (4) @(posedge clock_i);
    wr(6'h00, 16'h0000);
    rd(6'h34, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the read edge
  always @(posedge clock_i) rd_seen <= rd_i;
  always @(negedge clock_i) begin
    if (rd_seen === 1'b1) begin
      chk("rdata_o", exp_q.pop_front(), rdata_o);
    end
  end

  initial begin
    #2000000;
    n_mismatch++;
    print_verdict;
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 6'h00;
    wdata_i = 16'h0000;
    rd_seen = 1'b0;
    n_mismatch = 0;
    checks = 0;
    void'($urandom(66598));
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int c = 1; c < 4; c++) begin
      rd(6'(c * 16), 16'h00c0);
      rd(6'(c * 16 + 1), 16'h0000);
      rd(6'(c * 16 + 2), 16'h0000);
    end
    rd(6'h3f, 16'h0000);
    wr(6'h10, 16'h00f3);
    rd(6'h10, 16'h00f3);
    wr(6'h20, 16'h0037);
    rd(6'h20, 16'h00c7);
    wr(6'h10, 16'h0000);
    wr(6'h20, 16'h0000);
    repeat (4) begin
      r = $urandom;
      v = {8'h00, 1'b0, r[6:4], 1'b0, r[2:0]};
      wr(6'h21, v);
      rd(6'h21, v);
      wr(6'h35, r[31:16]);
      rd(6'h35, r[31:16]);
    end
    for (int f = 0; f < 8; f++) begin
      wr(6'h11, {8'h00, 4'(f), 4'(f)});
      wr(6'h12, {8'h00, 4'(f), 4'(f)});
      repeat (2) @(posedge clock_i);
      pc(8'h0f, {4'h0, {4{f[1:0] != 2'h0}}}, 8'h0f, {4'h0, {4{f[2]}}});
    end
    wr(6'h10, 16'h0030);
    repeat (2) @(posedge clock_i);
    pc(8'h0f, 8'h03, 8'h03, 8'h03);
    rd(6'h10, 16'h00f0);
    wr(6'h10, 16'h0000);
    wr(6'h11, 16'h0023);
    wr(6'h12, 16'h0000);
    wr(6'h16, 16'h0008);
    for (int g = 7; g < 9; g++) begin
      wr(6'(16 + g), 16'h8000);
    end
    wr(6'h15, 16'h0005);
    wr(6'h14, 16'h0000);
    wr(6'h19, 16'h0000);
    wr(6'h13, 16'h0000);
    wr(6'h00, 16'h0001);
    repeat (20) @(posedge clock_i);
    pc(8'h03, 8'h03, 8'h03, 8'h03);
    rd(6'h13, 16'h0003);
    wr(6'h00, 16'h0000);
    repeat (2) @(posedge clock_i);
    pc(8'h03, 8'h03, 8'h03, 8'h00);
    wr(6'h13, 16'h0000);
    rd(6'h13, 16'h0000);
    // pwm mode 2 on ch0: period 8, B drives one at 3, every pin back to its initial level at clear
    wr(6'h10, 16'h0003);
    wr(6'h11, 16'h0024);
    wr(6'h15, 16'h0007);
    wr(6'h16, 16'h0003);
    wr(6'h14, 16'h0000);
    wr(6'h00, 16'h0001);
    repeat (20) @(posedge clock_i);
    pc(8'h03, 8'h02, 8'h03, 8'h03);
    // clock enable low for five edges must hold counter and pins across the next clear
    @(posedge clock_i);
    ce_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    pc(8'h03, 8'h02, 8'h03, 8'h03);
    @(posedge clock_i);
    ce_i <= 1'b1;
    wr(6'h00, 16'h0000);
    rd(6'h14, 16'h0007);
    rd(6'h13, 16'h0003);
    wr(6'h10, 16'h0000);
    // falling edge only: the rising edge must leave the flag clear
    wr(6'h21, 16'h0009);
    wr(6'h26, 16'h8000);
    wr(6'h24, 16'h0000);
    wr(6'h29, 16'h0002);
    wr(6'h23, 16'h0000);
    wr(6'h00, 16'h0002);
    P.set_pin(4, 1'b1);
    repeat (4) @(posedge clock_i);
    rd(6'h23, 16'h0000);
    P.set_pin(4, 1'b0);
    repeat (4) @(posedge clock_i);
    wr(6'h00, 16'h0000);
    rd(6'h23, 16'h0001);
    pc(8'h10, 8'h00, 8'h00, 8'h00);
    ext_run(3'h4, 0, 16'h0003);
    ext_run(3'h5, 1, 16'h0003);
    ext_run(3'h6, 2, 16'h0003);
    wr(6'h30, 16'h0004);
    ext_run(3'h6, 2, 16'h0000);
    wr(6'h30, 16'h0000);
    repeat (4) @(posedge clock_i);
    print_verdict;
  end
endmodule
